// [hdl/nspc_cfg.svh]
// Constants for the non-secure permission control register block
`ifndef NSPC_CFG_SVH
`define NSPC_CFG_SVH

// Coprocessor numbers
`define NSPC_COP_SYSCTRL    4'hf
`define NSPC_COP_DEBUG      4'he
`define NSPC_COP_FP_LO      4'ha
`define NSPC_COP_FP_HI      4'hb

// Register selectors: opcode1, primary, secondary, opcode2
`define NSPC_SEL_OPC1       3'h0
`define NSPC_SEL_CRN        4'h1
`define NSPC_SEL_CRM        4'h1
`define NSPC_SEL_OPC2       3'h2
`define NSPC_AUX_CRM        4'h0
`define NSPC_AUX_OPC2       3'h1
`define NSPC_COPROC_ACCESS_REGISTER_CRM      4'h0
`define NSPC_COPROC_ACCESS_REGISTER_OPC2     3'h2
`define NSPC_PRELOAD_CRN    4'hb

// Field positions of the permission register
`define NSPC_BIT_COH        18
`define NSPC_BIT_TLB        17
`define NSPC_BIT_PLE        16
`define NSPC_BIT_SIMD       15
`define NSPC_BIT_FPREG      14
`define NSPC_BIT_COP11      11
`define NSPC_BIT_COP10      10

// Field positions of the coprocessor access register
`define NSPC_CPA_SIMD       31
`define NSPC_CPA_FPREG      30
`define NSPC_CPA_COP11_HI   23
`define NSPC_CPA_COP11_LO   22
`define NSPC_CPA_COP10_HI   21
`define NSPC_CPA_COP10_LO   20

// Reset value of every permission bit
`define NSPC_RESET_BIT      1'b0

`endif

// [hdl/nspc_ctrl.sv]
// Non-secure permission control register and its access checks
//
// Behaviour
// - Register accessible only from privileged processor modes.
// - Secure state reads and writes; Non-secure state reads only, writes ignored.
// - Debug and system control coprocessor permissions are never changed here.
// - Coherency permit 0: Non-secure auxiliary write traps, coherency bit unchanged.
// - Coherency permit 1: Non-secure auxiliary write updates only the coherency bit.
// - TLB lock permit gates lockable TLB allocation in Non-secure state; reset 0.
// - Preload permit 0: every Non-secure preload register access traps.
// - Preload permit 1 allows Non-secure access; absent engine reads zero, ignores writes.
// - SIMD force 1 pins access register SIMD disable at 1 in Non-secure state.
// - Upper register force 1 pins access register bit at 1 in Non-secure state.
// - Coprocessor 11 permit 0 means Secure only, 1 allows both states.
// - Coprocessor 10 permit 0 means Secure only, 1 allows both states.
// - Non-secure access register fields take effect only as permits allow.
`timescale 1ns/100ps
`include "nspc_cfg.svh"

module nspc_ctrl #(
  parameter bit PRELOAD_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // Coprocessor transfer from the core
  input  wire logic        CP_VALID,
  input  wire logic        CP_WRITE,
  input  wire logic [3:0]  CP_NUM,
  input  wire logic [2:0]  CP_OPC1,
  input  wire logic [3:0]  CP_CRN,
  input  wire logic [3:0]  CP_CRM,
  input  wire logic [2:0]  CP_OPC2,
  input  wire logic [31:0] CP_WDATA,
  input  wire logic        CORE_SECURE,
  input  wire logic        CORE_PRIV,
  // Answer to the core
  output logic             CP_DONE,
  output logic             CP_UNDEF,
  output logic [31:0]      CP_RDATA,
  // Auxiliary control register write strobe
  output logic             AUX_WRITE_EN,
  output logic             AUX_WRITE_ALL,
  // Permission levels to the rest of the core
  output logic             NS_COHERENCY_WRITE_PERMIT,
  output logic             NS_TLB_LOCK_PERMIT,
  output logic             NS_PRELOAD_PERMIT,
  output logic             NS_SIMD_DISABLE_FORCE,
  output logic             NS_UPPER_FPREG_DISABLE_FORCE,
  output logic             NS_COP11_PERMIT,
  output logic             NS_COP10_PERMIT,
  // Coprocessor access register gating for the current state
  output logic [31:0]      COPROC_ACCESS_REGISTER_WRITE_MASK,
  output logic [31:0]      COPROC_ACCESS_REGISTER_READ_SET,
  output logic [31:0]      COPROC_ACCESS_REGISTER_READ_CLEAR
);

  nspc_pkg::nspc_state_t  st;
  nspc_pkg::nspc_state_t  next_st;
  nspc_pkg::nspc_target_t tgt;
  logic                   ns;
  logic                   trap;
  logic [31:0]            perm_word;

  // Permits restrict Non-secure state only; Secure state is never gated
  assign ns = ~CORE_SECURE;

  // Target decode; coprocessors 14 and 15 other than our selectors pass untouched
  always_comb begin
    tgt = nspc_pkg::NSPC_TGT_OTHER;
    if (CP_NUM == `NSPC_COP_FP_LO) begin
      tgt = nspc_pkg::NSPC_TGT_FP_LO;
    end else if (CP_NUM == `NSPC_COP_FP_HI) begin
      tgt = nspc_pkg::NSPC_TGT_FP_HI;
    end else if (CP_NUM != `NSPC_COP_SYSCTRL) begin
      tgt = nspc_pkg::NSPC_TGT_OTHER;
    end else if (CP_CRN == `NSPC_PRELOAD_CRN) begin
      tgt = nspc_pkg::NSPC_TGT_PRE;
    end else if (CP_OPC1 != `NSPC_SEL_OPC1 || CP_CRN != `NSPC_SEL_CRN) begin
      tgt = nspc_pkg::NSPC_TGT_OTHER;
    end else if (CP_CRM == `NSPC_SEL_CRM && CP_OPC2 == `NSPC_SEL_OPC2) begin
      tgt = nspc_pkg::NSPC_TGT_PERM;
    end else if (CP_CRM == `NSPC_AUX_CRM && CP_OPC2 == `NSPC_AUX_OPC2) begin
      tgt = nspc_pkg::NSPC_TGT_AUX;
    end else if (CP_CRM == `NSPC_COPROC_ACCESS_REGISTER_CRM && CP_OPC2 == `NSPC_COPROC_ACCESS_REGISTER_OPC2) begin
      tgt = nspc_pkg::NSPC_TGT_COPROC_ACCESS_REGISTER;
    end
  end

  // Trap decision for the transfer in flight
  always_comb begin
    trap = 1'b0;
    case (tgt)
      nspc_pkg::NSPC_TGT_PERM:  trap = ~CORE_PRIV;
      nspc_pkg::NSPC_TGT_AUX:   trap = ns & CP_WRITE & ~st.coh;
      nspc_pkg::NSPC_TGT_PRE:   trap = ns & ~st.ns_preload_permit;
      nspc_pkg::NSPC_TGT_FP_LO: trap = ns & ~st.cop10;
      nspc_pkg::NSPC_TGT_FP_HI: trap = ns & ~st.cop11;
      default:                  trap = 1'b0;
    endcase
  end

  // Read image; reserved ranges are zero
  always_comb begin
    perm_word                   = 32'h0000_0000;
    perm_word[`NSPC_BIT_COH]    = st.coh;
    perm_word[`NSPC_BIT_TLB]    = st.tlb;
    perm_word[`NSPC_BIT_PLE]    = st.ns_preload_permit;
    perm_word[`NSPC_BIT_SIMD]   = st.simd;
    perm_word[`NSPC_BIT_FPREG]  = st.fpreg;
    perm_word[`NSPC_BIT_COP11]  = st.cop11;
    perm_word[`NSPC_BIT_COP10]  = st.cop10;
  end

  always_comb begin
    next_st         = st;
    next_st.done    = CP_VALID;
    next_st.undef   = CP_VALID & trap;
    next_st.aux_we  = 1'b0;
    next_st.aux_all = 1'b0;
    next_st.rdata   = 32'h0000_0000;
    if (CP_VALID && !trap) begin
      if (tgt == nspc_pkg::NSPC_TGT_PERM && !CP_WRITE) begin
        next_st.rdata = perm_word;
      end
      // Non-secure writes acknowledged but dropped
      if (tgt == nspc_pkg::NSPC_TGT_PERM && CP_WRITE && CORE_SECURE) begin
        next_st.coh   = CP_WDATA[`NSPC_BIT_COH];
        next_st.tlb   = CP_WDATA[`NSPC_BIT_TLB];
        next_st.ns_preload_permit   = CP_WDATA[`NSPC_BIT_PLE] & PRELOAD_PRESENT;
        next_st.simd  = CP_WDATA[`NSPC_BIT_SIMD];
        next_st.fpreg = CP_WDATA[`NSPC_BIT_FPREG];
        next_st.cop11 = CP_WDATA[`NSPC_BIT_COP11];
        next_st.cop10 = CP_WDATA[`NSPC_BIT_COP10];
      end
      // Non-secure aux write may touch only the coherency bit
      if (tgt == nspc_pkg::NSPC_TGT_AUX && CP_WRITE) begin
        next_st.aux_we  = 1'b1;
        next_st.aux_all = CORE_SECURE;
      end
    end
    // Reset last, so a transfer offered during it is dropped
    if (SRST) begin
      next_st.coh     = `NSPC_RESET_BIT;
      next_st.tlb     = `NSPC_RESET_BIT;
      next_st.ns_preload_permit     = `NSPC_RESET_BIT;
      next_st.simd    = `NSPC_RESET_BIT;
      next_st.fpreg   = `NSPC_RESET_BIT;
      next_st.cop11   = `NSPC_RESET_BIT;
      next_st.cop10   = `NSPC_RESET_BIT;
      next_st.done    = 1'b0;
      next_st.undef   = 1'b0;
      next_st.aux_we  = 1'b0;
      next_st.aux_all = 1'b0;
      next_st.rdata   = 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    st <= next_st;
  end

  // Answer is registered: the core sees it one edge after the request
  assign CP_DONE       = st.done;
  assign CP_UNDEF      = st.undef;
  assign CP_RDATA      = st.rdata;
  assign AUX_WRITE_EN  = st.aux_we;
  assign AUX_WRITE_ALL = st.aux_all;

  assign NS_COHERENCY_WRITE_PERMIT    = st.coh;
  assign NS_TLB_LOCK_PERMIT           = st.tlb;
  assign NS_PRELOAD_PERMIT            = st.ns_preload_permit;
  assign NS_SIMD_DISABLE_FORCE        = st.simd;
  assign NS_UPPER_FPREG_DISABLE_FORCE = st.fpreg;
  assign NS_COP11_PERMIT              = st.cop11;
  assign NS_COP10_PERMIT              = st.cop10;

  // Access register gating; a field without permit reads as denied in Non-secure state
  always_comb begin
    COPROC_ACCESS_REGISTER_WRITE_MASK = 32'h0000_0000;
    COPROC_ACCESS_REGISTER_READ_SET   = 32'h0000_0000;
    COPROC_ACCESS_REGISTER_READ_CLEAR = 32'h0000_0000;
    COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_SIMD]  = CORE_SECURE | ~st.simd;
    COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_FPREG] = CORE_SECURE | ~st.fpreg;
    COPROC_ACCESS_REGISTER_READ_SET[`NSPC_CPA_SIMD]    = ns & st.simd;
    COPROC_ACCESS_REGISTER_READ_SET[`NSPC_CPA_FPREG]   = ns & st.fpreg;
    COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_COP11_HI:`NSPC_CPA_COP11_LO] =
      {2{CORE_SECURE | st.cop11}};
    COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_COP10_HI:`NSPC_CPA_COP10_LO] =
      {2{CORE_SECURE | st.cop10}};
    COPROC_ACCESS_REGISTER_READ_CLEAR[`NSPC_CPA_COP11_HI:`NSPC_CPA_COP11_LO] = {2{ns & ~st.cop11}};
    COPROC_ACCESS_REGISTER_READ_CLEAR[`NSPC_CPA_COP10_HI:`NSPC_CPA_COP10_LO] = {2{ns & ~st.cop10}};
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  logic perm_acc;
  assign perm_acc = CP_VALID && tgt == nspc_pkg::NSPC_TGT_PERM;

  a_user_trap: assert property (perm_acc && !CORE_PRIV |=> CP_UNDEF && CP_DONE)
    else $error("User mode access to permission register not trapped");

  a_priv_pass: assert property (perm_acc && CORE_PRIV |=> !CP_UNDEF && CP_DONE)
    else $error("Privileged access to permission register trapped");

  a_ns_write_hold: assert property (perm_acc && CP_WRITE && ns |=> $stable(perm_word))
    else $error("Non-secure write changed the permission register");

  a_sec_write: assert property (perm_acc && CP_WRITE && CORE_SECURE && CORE_PRIV
      |=> NS_COP10_PERMIT == $past(CP_WDATA[`NSPC_BIT_COP10])
       && NS_TLB_LOCK_PERMIT == $past(CP_WDATA[`NSPC_BIT_TLB]))
    else $error("Secure write did not update the permission register");

  a_dbg_pass: assert property (CP_VALID && CP_NUM == `NSPC_COP_DEBUG |=> !CP_UNDEF)
    else $error("Debug coprocessor access trapped");

  a_aux_trap: assert property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_AUX && CP_WRITE && ns
      && !st.coh |=> CP_UNDEF && !AUX_WRITE_EN)
    else $error("Non-secure auxiliary write not trapped");

  a_aux_coh_only: assert property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_AUX && CP_WRITE
      && ns && st.coh |=> AUX_WRITE_EN && !AUX_WRITE_ALL && !CP_UNDEF)
    else $error("Permitted auxiliary write not limited to coherency bit");

  a_tlb_level: assert property (perm_acc && !CP_WRITE && CORE_PRIV
      |=> CP_RDATA[`NSPC_BIT_TLB] == NS_TLB_LOCK_PERMIT)
    else $error("Lock permit level differs from register");

  a_pre_trap: assert property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_PRE && ns
      |=> CP_UNDEF == !$past(st.ns_preload_permit))
    else $error("Preload register access gating wrong");

  a_pre_absent: assert property (!PRELOAD_PRESENT |-> !NS_PRELOAD_PERMIT)
    else $error("Absent preload engine permit set");

  a_simd_force: assert property (ns && NS_SIMD_DISABLE_FORCE
      |-> COPROC_ACCESS_REGISTER_READ_SET[`NSPC_CPA_SIMD] && !COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_SIMD])
    else $error("SIMD disable not pinned");

  a_fpreg_force: assert property (ns && NS_UPPER_FPREG_DISABLE_FORCE
      |-> COPROC_ACCESS_REGISTER_READ_SET[`NSPC_CPA_FPREG] && !COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_FPREG])
    else $error("Upper register disable not pinned");

  a_cop11_gate: assert property (CP_VALID && CP_NUM == `NSPC_COP_FP_HI
      |=> CP_UNDEF == ($past(ns) && !NS_COP11_PERMIT))
    else $error("Coprocessor 11 gating wrong");

  a_cop10_gate: assert property (CP_VALID && CP_NUM == `NSPC_COP_FP_LO
      |=> CP_UNDEF == ($past(ns) && !NS_COP10_PERMIT))
    else $error("Coprocessor 10 gating wrong");

  a_coproc_access_register_gate: assert property (ns && !NS_COP10_PERMIT
      |-> COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_COP10_LO] == 1'b0
       && COPROC_ACCESS_REGISTER_READ_CLEAR[`NSPC_CPA_COP10_HI] == 1'b1)
    else $error("Access register field not gated");

  a_reserved_zero: assert property (##1 CP_RDATA[31:19] == 13'h0000
      && CP_RDATA[13:12] == 2'h0 && CP_RDATA[9:0] == 10'h000)
    else $error("Reserved bits read nonzero");

  a_reset_clear: assert property ($fell(SRST) |-> perm_word == 32'h0000_0000
      && !CP_DONE)
    else $error("Permission register not cleared by reset");

  a_done_follow: assert property (CP_VALID |=> CP_DONE)
    else $error("Transfer not answered");

  a_idle_quiet: assert property (!CP_VALID
      |=> !CP_DONE && !CP_UNDEF && !AUX_WRITE_EN)
    else $error("Answer without a transfer");

  a_ns_read: assert property (perm_acc && !CP_WRITE && ns && CORE_PRIV
      |=> !CP_UNDEF && CP_RDATA == $past(perm_word))
    else $error("Non-secure read of permission register refused");

  a_permit_hold: assert property (!(perm_acc && CP_WRITE && CORE_SECURE && CORE_PRIV)
      |=> $stable(perm_word))
    else $error("Permission register changed without a Secure write");

  a_aux_sec_all: assert property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_AUX
      && CP_WRITE && CORE_SECURE |=> AUX_WRITE_EN && AUX_WRITE_ALL && !CP_UNDEF)
    else $error("Secure auxiliary write not passed whole");

  a_other_pass: assert property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_OTHER
      |=> !CP_UNDEF && !AUX_WRITE_EN)
    else $error("Unrelated transfer trapped or strobed");

  a_cop11_coproc_access_register: assert property (ns && !NS_COP11_PERMIT
      |-> COPROC_ACCESS_REGISTER_WRITE_MASK[`NSPC_CPA_COP11_LO] == 1'b0
       && COPROC_ACCESS_REGISTER_READ_CLEAR[`NSPC_CPA_COP11_HI] == 1'b1)
    else $error("Coprocessor 11 access register field not gated");

  a_rdata_idle: assert property (!(perm_acc && !CP_WRITE)
      |=> CP_RDATA == 32'h0000_0000)
    else $error("Read data shown without a register read");

  c_sec_write: cover property (perm_acc && CP_WRITE && CORE_SECURE && CORE_PRIV);
  c_ns_read:   cover property (perm_acc && !CP_WRITE && ns && CORE_PRIV);
  c_ns_write:  cover property (perm_acc && CP_WRITE && ns && CORE_PRIV);
  c_aux_trap:  cover property (CP_VALID && tgt == nspc_pkg::NSPC_TGT_AUX && ns ##1 CP_UNDEF);
  c_fp_allow:  cover property (CP_VALID && CP_NUM == `NSPC_COP_FP_LO && ns ##1 !CP_UNDEF);

endmodule

// [hdl/nspc_pkg.sv]
// Types shared by the non-secure permission control block
package nspc_pkg;

  // Which register or coprocessor a transfer targets
  typedef enum logic [2:0] {
    NSPC_TGT_OTHER = 3'h0,
    NSPC_TGT_PERM  = 3'h1,
    NSPC_TGT_AUX   = 3'h3,
    NSPC_TGT_COPROC_ACCESS_REGISTER = 3'h2,
    NSPC_TGT_PRE   = 3'h6,
    NSPC_TGT_FP_LO = 3'h7,
    NSPC_TGT_FP_HI = 3'h5
  } nspc_target_t;

  // Whole state of the block
  typedef struct packed {
    logic        coh;
    logic        tlb;
    logic        ns_preload_permit;
    logic        simd;
    logic        fpreg;
    logic        cop11;
    logic        cop10;
    logic        done;
    logic        undef;
    logic        aux_we;
    logic        aux_all;
    logic [31:0] rdata;
  } nspc_state_t;

endpackage

// [tb/nspc_ctrl_tb.sv]
// Self-checking bench for the non-secure permission control block
`timescale 1ns/100ps
`include "nspc_cfg.svh"

module nspc_ctrl_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        cp_valid = 1'b0;
  logic        cp_write = 1'b0;
  logic [3:0]  cp_num = 4'h0;
  logic [3:0]  cp_crn = 4'h0;
  logic [3:0]  cp_crm = 4'h0;
  logic [2:0]  cp_opc1 = 3'h0;
  logic [2:0]  cp_opc2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0;
  logic        core_secure = 1'b0;
  logic        core_priv = 1'b0;
  logic        cp_done;
  logic        cp_undef;
  logic [31:0] cp_rdata;
  logic        aux_we;
  logic        aux_all;
  logic [6:0]  perm;
  logic [31:0] wmask;
  logic [31:0] rset;
  logic [31:0] rclr;
  logic        nopre_ple;
  logic [31:0] nopre_rdata;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  // Rows: coprocessor, primary, secondary, write, opcode2
  logic [15:0] tbl [6] = '{16'hf109, 16'hfb00, 16'ha000, 16'hb000, 16'he000, 16'hf200};

  always #2 ref_clk = ~ref_clk;

  nspc_ctrl #(.PRELOAD_PRESENT(1'b1)) dut (
    .REF_CLK(ref_clk), .SRST(srst), .CP_VALID(cp_valid), .CP_WRITE(cp_write),
    .CP_NUM(cp_num), .CP_OPC1(cp_opc1), .CP_CRN(cp_crn), .CP_CRM(cp_crm), .CP_OPC2(cp_opc2),
    .CP_WDATA(cp_wdata), .CORE_SECURE(core_secure), .CORE_PRIV(core_priv),
    .CP_DONE(cp_done), .CP_UNDEF(cp_undef), .CP_RDATA(cp_rdata),
    .AUX_WRITE_EN(aux_we), .AUX_WRITE_ALL(aux_all),
    .NS_COHERENCY_WRITE_PERMIT(perm[6]), .NS_TLB_LOCK_PERMIT(perm[5]),
    .NS_PRELOAD_PERMIT(perm[4]), .NS_SIMD_DISABLE_FORCE(perm[3]),
    .NS_UPPER_FPREG_DISABLE_FORCE(perm[2]), .NS_COP11_PERMIT(perm[1]),
    .NS_COP10_PERMIT(perm[0]), .COPROC_ACCESS_REGISTER_WRITE_MASK(wmask), .COPROC_ACCESS_REGISTER_READ_SET(rset),
    .COPROC_ACCESS_REGISTER_READ_CLEAR(rclr)
  );

  // Same stimulus into a build without the preload engine
  nspc_ctrl #(.PRELOAD_PRESENT(1'b0)) dut_nopre (
    .REF_CLK(ref_clk), .SRST(srst), .CP_VALID(cp_valid), .CP_WRITE(cp_write),
    .CP_NUM(cp_num), .CP_OPC1(cp_opc1), .CP_CRN(cp_crn), .CP_CRM(cp_crm), .CP_OPC2(cp_opc2),
    .CP_WDATA(cp_wdata), .CORE_SECURE(core_secure), .CORE_PRIV(core_priv),
    .CP_DONE(), .CP_UNDEF(), .CP_RDATA(nopre_rdata),
    .AUX_WRITE_EN(), .AUX_WRITE_ALL(),
    .NS_COHERENCY_WRITE_PERMIT(), .NS_TLB_LOCK_PERMIT(),
    .NS_PRELOAD_PERMIT(nopre_ple), .NS_SIMD_DISABLE_FORCE(),
    .NS_UPPER_FPREG_DISABLE_FORCE(), .NS_COP11_PERMIT(),
    .NS_COP10_PERMIT(), .COPROC_ACCESS_REGISTER_WRITE_MASK(), .COPROC_ACCESS_REGISTER_READ_SET(),
    .COPROC_ACCESS_REGISTER_READ_CLEAR()
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Called just after a rising edge; request is taken at the next one
  task automatic drive(input logic [15:0] row, input logic [31:0] wd, input logic sec,
                       input logic prv);
    cp_valid    <= 1'b1;
    {cp_num, cp_crn, cp_crm, cp_write, cp_opc2} <= row;
    cp_wdata    <= wd;
    core_secure <= sec;
    core_priv   <= prv;
  endtask

  // Single transfer; answer stands for the cycle after return
  task automatic xfer(input logic [15:0] row, input logic [31:0] wd, input logic sec,
                      input logic prv);
    @(posedge ref_clk);
    drive(row, wd, sec, prv);
    @(posedge ref_clk);
    cp_valid <= 1'b0;
    #1;
  endtask

  // Walk the four gated targets and two ungated ones in Non-secure state
  task automatic walk(input logic open);
    for (int i = 0; i < 6; i++) begin
      xfer(tbl[i], 32'h0, 1'b0, 1'b1);
      chk(cp_done, 1'b1);
      chk(cp_undef, (i < 4) && !open);
      chk(aux_we, (i == 0) && open);
      if (i == 0 && open) chk(aux_all, 1'b0);
    end
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    xfer(16'hf112, 32'h0, 1'b1, 1'b1);
    chk(cp_undef, 1'b0);
    chk(cp_rdata, 32'h0);
    chk(perm, 7'h00);
    // User mode access traps and leaves contents alone
    xfer(16'hf11a, 32'hffffffff, 1'b1, 1'b0);
    chk(cp_undef, 1'b1);
    xfer(16'hf112, 32'h0, 1'b1, 1'b0);
    chk(cp_undef, 1'b1);
    chk(perm, 7'h00);
    walk(1'b0);
    chk(wmask, 32'hc0000000);
    chk(rset, 32'h0);
    chk(rclr, 32'h00f00000);
    // Non-secure write is silently dropped
    xfer(16'hf11a, 32'hffffffff, 1'b0, 1'b1);
    chk({cp_done, cp_undef}, 2'b10);
    xfer(16'hf112, 32'h0, 1'b0, 1'b1);
    chk({cp_done, cp_undef}, 2'b10);
    chk(cp_rdata, 32'h0);
    xfer(16'hf11a, 32'hffffffff, 1'b1, 1'b1);
    chk(perm, 7'h7f);
    chk(nopre_ple, 1'b0);
    xfer(16'hf112, 32'h0, 1'b1, 1'b1);
    chk(cp_rdata, 32'h0007cc00);
    chk(nopre_rdata, 32'h0006cc00);
    // Another opcode1 selects some other register: no trap, no write
    @(posedge ref_clk);
    cp_opc1 <= 3'h1;
    xfer(16'hf11a, 32'h0, 1'b1, 1'b0);
    chk({cp_done, cp_undef}, 2'b10);
    chk(perm, 7'h7f);
    @(posedge ref_clk);
    cp_opc1 <= 3'h0;
    walk(1'b1);
    chk(wmask, 32'h00f00000);
    chk(rset, 32'hc0000000);
    chk(rclr, 32'h0);
    xfer(16'hf109, 32'h0, 1'b1, 1'b1);
    chk({aux_we, aux_all, cp_undef}, 3'b110);
    chk(wmask, 32'hc0f00000);
    chk(rset | rclr, 32'h0);
    // Back to back: the new permit applies to the very next transfer
    @(posedge ref_clk);
    drive(16'hf11a, 32'h00000400, 1'b1, 1'b1);
    @(posedge ref_clk);
    drive(16'ha000, 32'h0, 1'b0, 1'b1);
    #1;
    chk(cp_done, 1'b1);
    @(posedge ref_clk);
    drive(16'hb000, 32'h0, 1'b0, 1'b1);
    #1;
    chk({cp_done, cp_undef}, 2'b10);
    chk(perm, 7'h01);
    @(posedge ref_clk);
    cp_valid <= 1'b0;
    #1;
    chk({cp_done, cp_undef}, 2'b11);
    // Reset in mid-run with a transfer offered during it
    @(posedge ref_clk);
    srst <= 1'b1;
    drive(16'hf112, 32'h0, 1'b1, 1'b1);
    repeat (2) @(posedge ref_clk);
    srst     <= 1'b0;
    cp_valid <= 1'b0;
    #1;
    chk(cp_done, 1'b0);
    chk(perm, 7'h00);
    // First transfer after the release is served normally
    xfer(16'hf112, 32'h0, 1'b1, 1'b1);
    chk({cp_done, cp_undef}, 2'b10);
    chk(cp_rdata, 32'h0);
    tally_and_finish();
  end
endmodule
